// [src/diag_log_defs.svh]
// constants for the diagnostic log sector builder: register map, sector layout, counter layout
// assumes an APB master with 32-bit data and a 100 MHz MCLK
//
// Behaviour
// - self-test log byte 00h holds revision 01h, byte 01h stays reserved
// - bytes 02h-03h give newest descriptor index, 0 to 18, zero before any test
// - nineteen 26-byte descriptors from 04h, second at 1Eh, used as a ring
// - after wrapping, new tests overwrite entry 1, then entry 2, and onward
// - descriptor slots never written read as all-zero bytes
// - 512-byte sector: last entry 1D8h, vendor 1F2h, reserved 1F4h, checksum 1FFh
// - descriptor: number, status, hours, check point, 48-bit LBA low first, vendor bytes
// - both 48-bit and 28-bit tests are logged; every short-log test appears here
// - error sector byte 0: tag in bits 4-0 when flag bit 7 clear; 6-5 reserved
// - flag set for non-queued command errors, clear for the tagged queued command
// - bytes 1-13 snapshot the shadow registers at the moment the error is reported
// - byte 511 is two's complement of the sum of bytes 0-510
// - event counters clear at power-up, on BIST activate and on page 11h read-clear; kept over link and software resets
// - a BIST activate frame from the host clears all event counters
// - page 11h read with feature bit 0 returns values first, then clears counters
// - counter identifier bits 14-12 give width: 1h 16, 2h 32, 3h 48, 4h 64 bits
`ifndef DIAG_LOG_DEFS_SVH
`define DIAG_LOG_DEFS_SVH

// register byte addresses
`define REG_CTRL      12'h000
`define REG_PTR       12'h004
`define REG_DATA      12'h008
`define REG_STAGE     12'h00c
`define REG_COMMIT    12'h010
`define REG_STATUS    12'h014

// control word fields
`define CTRL_START    8
`define CTRL_FEAT0    2
`define STAGE_OFS_LSB 8
`define COMMIT_SHORT  0

// sector layout
`define ST_REVISION   8'h01
`define ST_IDX_LO     9'h002
`define ST_IDX_HI     9'h003
`define ST_DESC_BASE  9'h004
`define ST_DESC_END   9'h1f2
`define ST_DESC_LEN   9'h01a
`define ST_NUM_DESC   5'h13
`define ST_LAST_SLOT  5'h12
`define ST_LBA_B3     5'h08
`define ST_LBA_B5     5'h0a
`define SECT_LAST_SUM 9'h1fe
`define SECT_CKSUM    9'h1ff
`define CE_SNAP_FIRST 9'h001
`define CE_SNAP_LAST  9'h00d
`define CE_NQ_BIT     7
`define PE_FIRST      9'h004
`define PE_END        9'h018
`define PE_NUM        5
`define PE_SIZE_16    3'h1
`define PE_IDS        {12'h00d, 12'h00b, 12'h00a, 12'h009, 12'h001}

`endif

// [src/diag_log_pkg.sv]
// types shared by the diagnostic log sector builder
// assumes nothing beyond a SystemVerilog compiler
package diag_log_pkg;

    typedef enum logic [1:0] {
        SEC_SELFTEST = 2'h0,
        SEC_CMDERR   = 2'h1,
        SEC_PHYEVT   = 2'h2,
        SEC_NONE     = 2'h3
    } sector_e;

    // gray path idle -> scan -> done, and a new start goes done -> scan
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_SCAN = 2'h1,
        ST_DONE = 2'h3
    } scan_e;

    // error report from the command layer, shadow bytes 1..13 in order
    typedef struct packed {
        logic        non_queued;
        logic [4:0]  tag;
        logic [12:0][7:0] shadow;
    } err_report_s;

endpackage

// [src/phy_event_counter.sv]
// one physical event counter, 16 bits wide
// assumes event and clear are synchronous single-cycle pulses on clk
`timescale 1ns/100ps
module phy_event_counter (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        event_hit,
    input  wire logic        clear,
    output logic [15:0]      value
);

    // only the power-on reset and the explicit clear touch the count;
    // an event landing on a clear cycle is counted, not lost
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value <= 16'h0000;
        end else if (clear) begin
            value <= {15'h0000, event_hit};
        end else if (event_hit && value != 16'hffff) begin
            value <= value + 16'h0001; // saturate rather than wrap to a small count
        end
    end

endmodule

// [src/diag_log_builder.sv]
// diagnostic log sector builder: self-test ring, command error capture, event counters
// assumes an APB master on MCLK, synchronous event inputs, RESET only at power-up
`timescale 1ns/100ps
`include "diag_log_defs.svh"
module diag_log_builder (
    input  wire logic                      MCLK,
    input  wire logic                      RESET,
    input  wire logic                      PSEL,
    input  wire logic                      PENABLE,
    input  wire logic                      PWRITE,
    input  wire logic [11:0]               PADDR,
    input  wire logic [31:0]               PWDATA,
    output logic                           PREADY,
    output logic [31:0]                    PRDATA,
    output logic                           PSLVERR,
    input  wire logic [`PE_NUM-1:0]        PHY_EVENT,
    input  wire logic                      BIST_ACTIVATE,
    input  wire logic                      ERROR_REPORT,
    input  wire diag_log_pkg::err_report_s ERROR_INFO
);

    ////////////////////////////////////////////////////////////////////////////
    // state

    logic [7:0]                st_mem [0:493];
    logic [7:0]                stage [0:25];
    logic [18:0]               st_valid;
    logic [4:0]                st_idx;
    diag_log_pkg::err_report_s ce;
    logic [`PE_NUM-1:0][15:0]  cnt;
    logic [`PE_NUM-1:0][15:0]  snap;
    logic                      cnt_clear;
    diag_log_pkg::sector_e     sel;
    logic                      feat0;
    diag_log_pkg::scan_e       state;
    logic [8:0]                scan_addr;
    logic [7:0]                sum;
    logic [7:0]                cksum;
    logic [6:0]                ptr;
    logic                      setup;
    logic                      wr_en;
    logic                      start;
    logic                      commit;
    logic [4:0]                next_slot;
    logic [31:0]               next_rdata;
    logic                      next_err;

    localparam logic [59:0] PE_IDS = `PE_IDS;

    ////////////////////////////////////////////////////////////////////////////
    // byte view of the selected sector

    function automatic logic [7:0] sector_byte(input diag_log_pkg::sector_e s, input logic [8:0] a);
        logic [8:0]  rel;
        logic [4:0]  slot;
        logic [8:0]  pe_rel;
        logic [2:0]  k;
        logic [15:0] ident;
        logic [7:0]  b;
        rel    = a - `ST_DESC_BASE;
        slot   = 5'(rel / `ST_DESC_LEN);
        pe_rel = a - `PE_FIRST;
        k      = 3'(pe_rel >> 2);
        ident  = {1'b0, `PE_SIZE_16, PE_IDS[12*k +: 12]};
        b      = 8'h00;
        if (a == `SECT_CKSUM) begin
            b = cksum;
        end else begin
            case (s)
                diag_log_pkg::SEC_SELFTEST: begin
                    if (a == 9'h000) begin
                        b = `ST_REVISION;
                    end else if (a == `ST_IDX_LO) begin
                        b = {3'h0, st_idx};
                    end else if (a >= `ST_DESC_BASE && a < `ST_DESC_END && st_valid[slot]) begin
                        b = st_mem[rel];
                    end
                end
                diag_log_pkg::SEC_CMDERR: begin
                    if (a == 9'h000) begin
                        b = ce.non_queued ? 8'h80 : {3'h0, ce.tag};
                    end else if (a >= `CE_SNAP_FIRST && a <= `CE_SNAP_LAST) begin
                        b = ce.shadow[4'(a - `CE_SNAP_FIRST)];
                    end
                end
                diag_log_pkg::SEC_PHYEVT: begin
                    if (a >= `PE_FIRST && a < `PE_END) begin
                        case (pe_rel[1:0])
                            2'h0:    b = ident[7:0];
                            2'h1:    b = ident[15:8];
                            2'h2:    b = snap[k][7:0];
                            default: b = snap[k][15:8];
                        endcase
                    end
                end
                default: b = 8'h00;
            endcase
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // apb decode: no wait states, answer registered in the setup cycle

    assign setup     = PSEL && !PENABLE;
    assign wr_en     = PSEL && PENABLE && PREADY && PWRITE;
    assign start     = wr_en && PADDR == `REG_CTRL && PWDATA[`CTRL_START] && state != diag_log_pkg::ST_SCAN;
    assign commit    = wr_en && PADDR == `REG_COMMIT;
    assign next_slot = (st_valid == 19'h00000) ? 5'h00 :
                       (st_idx == `ST_LAST_SLOT) ? 5'h00 : st_idx + 5'h01;

    // read mux; the data word is four sector bytes, lowest address in the low lane
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err   = 1'b0;
        case (PADDR)
            `REG_CTRL:   next_rdata = {29'h0000_0000, feat0, sel};
            `REG_PTR:    next_rdata = {25'h000_0000, ptr};
            `REG_DATA: begin
                for (int i = 0; i < 4; i++) begin
                    next_rdata[8*i +: 8] = sector_byte(sel, {ptr, 2'(i)});
                end
            end
            `REG_STAGE:  next_rdata = 32'h0000_0000;
            `REG_COMMIT: next_rdata = {27'h000_0000, st_idx};
            `REG_STATUS: next_rdata = {30'h0000_0000, state == diag_log_pkg::ST_DONE,
                                       state == diag_log_pkg::ST_SCAN};
            default:     next_err   = 1'b1;
        endcase
    end

    // handshake outputs, all from flops
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PRDATA  <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= setup;
            if (setup) begin
                PRDATA  <= PWRITE ? 32'h0000_0000 : next_rdata;
                PSLVERR <= next_err;
            end
        end
    end

    // control and pointer registers
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            sel   <= diag_log_pkg::SEC_SELFTEST;
            feat0 <= 1'b0;
            ptr   <= 7'h00;
        end else begin
            if (start) begin
                sel   <= diag_log_pkg::sector_e'(PWDATA[1:0]);
                feat0 <= PWDATA[`CTRL_FEAT0];
            end
            if (wr_en && PADDR == `REG_PTR) begin
                ptr <= PWDATA[6:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // self-test ring

    // staging buffer: firmware fills one descriptor byte by byte before commit
    always_ff @(posedge MCLK) begin
        if (wr_en && PADDR == `REG_STAGE && PWDATA[12:8] < 5'(`ST_DESC_LEN)) begin
            stage[PWDATA[12:8]] <= PWDATA[7:0];
        end
    end

    // commit copies the staged entry into the next ring slot; short-address tests
    // keep only 28 address bits so they sit beside 48-bit entries
    always_ff @(posedge MCLK) begin
        if (commit) begin
            for (int i = 0; i < int'(`ST_DESC_LEN); i++) begin
                if (PWDATA[`COMMIT_SHORT] && i == `ST_LBA_B3) begin
                    st_mem[next_slot * `ST_DESC_LEN + i] <= {4'h0, stage[i][3:0]};
                end else if (PWDATA[`COMMIT_SHORT] && i > `ST_LBA_B3 && i <= `ST_LBA_B5) begin
                    st_mem[next_slot * `ST_DESC_LEN + i] <= 8'h00;
                end else begin
                    st_mem[next_slot * `ST_DESC_LEN + i] <= stage[i];
                end
            end
        end
    end

    // ring index and written-slot flags; memory itself needs no reset
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            st_idx   <= 5'h00;
            st_valid <= 19'h00000;
        end else if (commit) begin
            st_idx             <= next_slot;
            st_valid[next_slot] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command error capture

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            ce <= '0;
        end else if (ERROR_REPORT) begin
            ce.non_queued <= ERROR_INFO.non_queued;
            ce.tag        <= ERROR_INFO.non_queued ? 5'h00 : ERROR_INFO.tag;
            ce.shadow     <= ERROR_INFO.shadow;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // physical event counters

    // a page 11h read with feature bit 0 snapshots first and clears on the same edge,
    // so the host sees the values from before the clear
    assign cnt_clear = BIST_ACTIVATE ||
                       (start && PWDATA[1:0] == 2'(diag_log_pkg::SEC_PHYEVT) && PWDATA[`CTRL_FEAT0]);

    for (genvar g = 0; g < `PE_NUM; g++) begin : g_cnt
        phy_event_counter u_cnt (
            .clk       (MCLK),
            .rst       (RESET),
            .event_hit (PHY_EVENT[g]),
            .clear     (cnt_clear),
            .value     (cnt[g])
        );
    end

    // snapshot taken at every page 11h start, with or without clear
    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            snap <= '0;
        end else if (start && PWDATA[1:0] == 2'(diag_log_pkg::SEC_PHYEVT)) begin
            snap <= cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checksum scan: one byte a cycle over bytes 0..510 of the chosen sector

    always_ff @(posedge MCLK or posedge RESET) begin
        if (RESET) begin
            state     <= diag_log_pkg::ST_IDLE;
            scan_addr <= 9'h000;
            sum       <= 8'h00;
            cksum     <= 8'h00;
        end else begin
            case (state)
                diag_log_pkg::ST_IDLE,
                diag_log_pkg::ST_DONE: begin
                    if (start) begin
                        state     <= diag_log_pkg::ST_SCAN;
                        scan_addr <= 9'h000;
                        sum       <= 8'h00;
                    end
                end
                diag_log_pkg::ST_SCAN: begin
                    sum       <= sum + sector_byte(sel, scan_addr);
                    scan_addr <= scan_addr + 9'h001;
                    if (scan_addr == `SECT_LAST_SUM) begin
                        cksum <= 8'h00 - (sum + sector_byte(sel, scan_addr));
                        state <= diag_log_pkg::ST_DONE;
                    end
                end
                default: state <= diag_log_pkg::ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RESET);

    chk_rev_byte: assert property (sector_byte(diag_log_pkg::SEC_SELFTEST, 9'h000) == 8'h01
                                   && sector_byte(diag_log_pkg::SEC_SELFTEST, 9'h001) == 8'h00)
        else $error("self-test revision byte wrong");
    chk_idx_range: assert property (st_idx <= 5'h12 && (st_valid == 19'h0 -> st_idx == 5'h00))
        else $error("self-test index out of range");
    chk_ring_wrap: assert property (commit && st_idx == 5'h12 |=> st_idx == 5'h00 && st_valid[0])
        else $error("ring did not wrap to entry 1");
    chk_ring_step: assert property (commit && st_valid != 19'h0 && st_idx < 5'h12
                                    |=> st_idx == $past(st_idx) + 5'h01)
        else $error("ring did not advance by one");
    chk_unused_zero: assert property (!st_valid[1] |-> sector_byte(diag_log_pkg::SEC_SELFTEST, 9'h01e) == 8'h00)
        else $error("unwritten descriptor not zero");
    chk_vendor_zero: assert property (sector_byte(diag_log_pkg::SEC_SELFTEST, 9'h1f2) == 8'h00)
        else $error("vendor field after last descriptor not zero");
    chk_nq_byte: assert property (ERROR_REPORT && ERROR_INFO.non_queued
                                  |=> sector_byte(diag_log_pkg::SEC_CMDERR, 9'h000) == 8'h80)
        else $error("non-queued flag not reported");
    chk_tag_byte: assert property (ERROR_REPORT && !ERROR_INFO.non_queued
                                   |=> sector_byte(diag_log_pkg::SEC_CMDERR, 9'h000) == {3'h0, $past(ERROR_INFO.tag)})
        else $error("queue tag not reported");
    chk_shadow_snap: assert property (ERROR_REPORT |=> ce.shadow == $past(ERROR_INFO.shadow)
                                      ##1 ($past(ERROR_REPORT) || $stable(ce.shadow)))
        else $error("shadow snapshot wrong");
    chk_sum_zero: assert property ($rose(state == diag_log_pkg::ST_DONE) |-> 8'(sum + cksum) == 8'h00)
        else $error("checksum does not close the sector");
    chk_bist_clear: assert property (BIST_ACTIVATE |=> cnt[0] <= 16'h0001 && cnt[4] <= 16'h0001)
        else $error("bist activate did not clear counters");
    chk_read_clear: assert property (cnt_clear && !BIST_ACTIVATE
                                     |=> snap == $past(cnt) && cnt[1] <= 16'h0001)
        else $error("read-and-clear order wrong");
    chk_read_keep: assert property (start && PWDATA[1:0] == 2'h2 && !PWDATA[2] && !BIST_ACTIVATE
                                    && PHY_EVENT == 5'h00 |=> cnt == $past(cnt))
        else $error("plain page 11h read changed counters");
    chk_ident_size: assert property (sector_byte(diag_log_pkg::SEC_PHYEVT, 9'h005) == 8'h10)
        else $error("counter size code wrong");
    chk_no_reset_else: assert property (!cnt_clear && PHY_EVENT[2] == 1'b0 |=> cnt[2] >= $past(cnt[2]))
        else $error("counter lost value without a clear");

    cov_wrap: cover property (commit && st_idx == 5'h12 && st_valid[18]);
    cov_read_clear: cover property (cnt_clear && !BIST_ACTIVATE ##[1:600] state == diag_log_pkg::ST_DONE);
    cov_queued_err: cover property (ERROR_REPORT && !ERROR_INFO.non_queued);
    cov_scan_done: cover property ($rose(state == diag_log_pkg::ST_DONE));

endmodule

// [sim/host_link_model.sv]
// host-side source of link events, error reports and BIST activate frames
// assumes the bench calls its tasks just after a rising clk edge
`timescale 1ns/100ps
module host_link_model (
    input  wire logic                 clk,
    output logic [4:0]                phy_event,
    output logic                      bist_activate,
    output logic                      error_report,
    output diag_log_pkg::err_report_s error_info
);
    ////////////////////////////////////////////////////////////////////////////////
    // quiet lines until the first frame
    initial begin
        phy_event     = 5'h00;
        bist_activate = 1'b0;
        error_report  = 1'b0;
        error_info    = '0;
    end

    // one-cycle event pulse on every counter set in mask
    task automatic events(input logic [4:0] mask);
        @(posedge clk);
        phy_event <= mask;
        @(posedge clk);
        phy_event <= 5'h00;
    endtask

    // activate frame clears every counter on the far side
    task automatic bist;
        @(posedge clk);
        bist_activate <= 1'b1;
        @(posedge clk);
        bist_activate <= 1'b0;
    endtask

    // report an error; afterwards the bus moves on, so a stale copy would show
    task automatic report(input diag_log_pkg::err_report_s info);
        @(posedge clk);
        error_info   <= info;
        error_report <= 1'b1;
        @(posedge clk);
        error_report <= 1'b0;
        error_info   <= ~info;
    endtask
endmodule

// [sim/diag_log_builder_tb.sv]
// bench for the diagnostic log sector builder: APB master tasks, one task per scenario
// assumes a one-access-cycle APB slave and the host model on the event inputs
`timescale 1ns/100ps
`include "diag_log_defs.svh"
module diag_log_builder_tb;
    logic                      mclk;
    logic                      reset;
    logic                      psel;
    logic                      penable;
    logic                      pwrite;
    logic [11:0]               paddr;
    logic [31:0]               pwdata;
    logic                      pready;
    logic [31:0]               prdata;
    logic                      pslverr;
    logic [4:0]                phy_event;
    logic                      bist_activate;
    logic                      error_report;
    diag_log_pkg::err_report_s error_info;
    logic [31:0]               q;
    logic                      e;
    logic [7:0]                b;
    int                        n_fail;
    int                        samples_checked;

    diag_log_builder u_diag_log_builder (
        .MCLK(mclk), .RESET(reset), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
        .PHY_EVENT(phy_event), .BIST_ACTIVATE(bist_activate), .ERROR_REPORT(error_report),
        .ERROR_INFO(error_info)
    );
    host_link_model u_host_link_model (
        .clk(mclk), .phy_event(phy_event), .bist_activate(bist_activate),
        .error_report(error_report), .error_info(error_info)
    );

    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // comparison and verdict
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // apb transfer: pready, prdata and pslverr are taken at the rising edge that ends the access
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_word(input int w);
        wr(`REG_PTR, 32'(w));
        apb(1'b0, `REG_DATA, 32'h0);
    endtask

    task automatic rd_byte(input int a);
        rd_word(a / 4);
        b = q[8*(a%4) +: 8];
    endtask

    // start a sector build and poll until done; the checksum is only good after it
    task automatic scan(input logic [1:0] sel, input logic feat);
        int n;
        wr(`REG_CTRL, {23'h0, 1'b1, 5'h0, feat, sel});
        n = 0;
        q = 32'h0;
        while (q[1] !== 1'b1 && n < 300) begin
            apb(1'b0, `REG_STATUS, 32'h0);
            n++;
        end
        check("scan done", {31'h0, q[1]}, 32'h1);
        if (q[1] !== 1'b1) begin
            tally_and_finish();
        end
    endtask

    task automatic check_sum;
        logic [7:0] s;
        s = 8'h00;
        for (int w = 0; w < 128; w++) begin
            rd_word(w);
            s = s + q[7:0] + q[15:8] + q[23:16] + q[31:24];
        end
        check("sector sum", 32'(s), 32'h0);
    endtask

    // staged descriptor: number, status (inverse of number), six lba bytes, all other bytes zero;
    // every staged byte is written since the staging buffer keeps whatever it held before
    task automatic commit(input logic [7:0] num, input logic [47:0] lba, input logic short28);
        logic [7:0] v;
        for (int k = 0; k < 26; k++) begin
            v = (k == 0) ? num : (k == 1) ? ~num : (k >= 5 && k < 11) ? lba[8*(k-5) +: 8] : 8'h00;
            wr(`REG_STAGE, {19'h0, 5'(k), v});
        end
        wr(`REG_COMMIT, {31'h0, short28});
    endtask

    task automatic check_desc(input int s, input logic [7:0] num, input logic [47:0] lba);
        rd_byte(4 + 26*s);
        check("test number", 32'(b), 32'(num));
        rd_byte(5 + 26*s);
        check("exec status", 32'(b), {24'h0, ~num});
        for (int k = 0; k < 6; k++) begin
            rd_byte(9 + 26*s + k);
            check("failing lba", 32'(b), 32'(lba[8*k +: 8]));
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        wr(`REG_CTRL, 32'h0);
        rd_word(0);
        check("revision and index", q, 32'h00000001);
        for (int w = 1; w < 8; w++) begin
            rd_word(w);
            check("empty slot", q, 32'h0);
        end
        apb(1'b0, 12'h018, 32'h0);
        check("unmapped err", {31'h0, e}, 32'h1);
        check("unmapped data", q, 32'h0);
    endtask

    // nineteen tests fill the ring, the twentieth (28-bit) lands in entry 1
    task automatic t_ring;
        for (int i = 1; i <= 19; i++) begin
            commit(8'(i), 48'h0a0908070605 + 48'(i), 1'b0);
            rd_word(0);
            check("index word", q, {8'h00, 8'(i - 1), 16'h0001});
        end
        check_desc(18, 8'd19, 48'h0a0908070605 + 48'd19);
        commit(8'd20, 48'hffffffffffff, 1'b1);
        check_desc(0, 8'd20, 48'h00000fffffff);
        check_desc(1, 8'd2, 48'h0a0908070607);
        rd_word(0);
        check("index wrap", q, 32'h00000001);
        scan(2'h0, 1'b0);
        check_sum();
        rd_word(125);
        check("reserved tail", q, 32'h0);
        rd_word(127);
        check("reserved tail", q & 32'h00ffffff, 32'h0);
    endtask

    task automatic t_error;
        diag_log_pkg::err_report_s info;
        info.non_queued = 1'b0;
        info.tag = 5'h15;
        for (int k = 0; k < 13; k++) begin
            info.shadow[k] = 8'h30 + 8'(k);
        end
        u_host_link_model.report(info);
        scan(2'h1, 1'b0);
        rd_byte(0);
        check("queued byte0", 32'(b), 32'h15);
        for (int k = 1; k < 14; k++) begin
            rd_byte(k);
            check("shadow copy", 32'(b), 32'h2f + 32'(k));
        end
        check_sum();
        info.non_queued = 1'b1;
        info.tag = 5'h0a;
        u_host_link_model.report(info);
        rd_byte(0);
        check("non-queued byte0", 32'(b), 32'h80);
    endtask

    // page 11h: counter k carries id table entry k and, after the pulses, k+1 counts
    task automatic check_counters(input logic feat, input int mult);
        logic [11:0] ids [5] = '{12'h001, 12'h009, 12'h00a, 12'h00b, 12'h00d};
        scan(2'h2, feat);
        for (int k = 0; k < 5; k++) begin
            rd_word(k + 1);
            check("counter id", {16'h0, q[15:0]}, {16'h0, 4'h1, ids[k]});
            check("counter value", {16'h0, q[31:16]}, 32'(mult * (k + 1)));
        end
    endtask

    task automatic t_counters;
        check_counters(1'b0, 0);
        for (int j = 0; j < 5; j++) begin
            u_host_link_model.events(5'(5'h1f << j));
        end
        check_counters(1'b0, 1);
        check_counters(1'b0, 1);
        check_counters(1'b1, 1);
        check_sum();
        check_counters(1'b0, 0);
        u_host_link_model.events(5'h1f);
        u_host_link_model.bist();
        check_counters(1'b0, 0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence: power-on reset for 16 cycles, then the scenarios
    initial begin
        reset   = 1'b1;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0;
        n_fail  = 0;
        samples_checked = 0;
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_ring();
        t_error();
        t_counters();
        tally_and_finish();
    end
endmodule
